// file: dct_top.sv
// dual counter/timer pulse unit: two units, time base, register port
// assumes external clock and gate pins are asynchronous to i_clk
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module dct_top
	import dct_pkg::*;
(
	input wire logic i_clk, // system clock 100 MHz
	input wire logic i_rstn, // sync reset, low
	input wire logic [7:0] i_addr, // register byte address
	input wire logic [31:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [31:0] o_rdata, // read data, cycle after i_rd
	input wire logic [1:0] i_ext_clk, // external clock pins
	input wire logic [1:0] i_gate, // gate pins
	output logic [1:0] o_pulse // pulse output pins
);
	// ==============================================================
	// registers
	logic [31:0] ctrl [2];
	logic [15:0] div [2];
	logic casc;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			ctrl[0] <= CTRL_RST;
			ctrl[1] <= CTRL_RST;
			div[0] <= DIV_RST;
			div[1] <= DIV_RST;
			casc <= 1'b0;
		end else if (i_wr) begin
			unique case (i_addr)
				A_CTRL0: ctrl[0] <= i_wdata;
				A_CTRL1: ctrl[1] <= i_wdata;
				A_DIV0: div[0] <= i_wdata[15:0];
				A_DIV1: div[1] <= i_wdata[15:0];
				A_CASC: casc <= i_wdata[0];
				default: ;
			endcase
		end
	end

	// ==============================================================
	// pin synchronisers and edge detection
	logic [1:0] clk_s1, clk_s2, clk_s3;
	logic [1:0] gt_s1, gt_s2, gt_s3;
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			clk_s1 <= 2'h0;
			clk_s2 <= 2'h0;
			clk_s3 <= 2'h0;
			gt_s1 <= 2'h0;
			gt_s2 <= 2'h0;
			gt_s3 <= 2'h0;
		end else begin
			clk_s1 <= i_ext_clk;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
			gt_s1 <= i_gate;
			gt_s2 <= gt_s1;
			gt_s3 <= gt_s2;
		end
	end

	// ==============================================================
	// 12.5 MHz time base tick (divide by 8)
	logic [3:0] tb_cnt;
	logic tb_tick;
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			tb_cnt <= 4'h0;
		end else begin
			tb_cnt <= (tb_cnt == TB_DIV_M1) ? 4'h0 : tb_cnt + 4'h1;
		end
	end
	assign tb_tick = (tb_cnt == TB_DIV_M1);

	// ==============================================================
	// clock source selection and units
	logic [1:0] tick;
	logic [1:0] clk_out;
	logic [15:0] cnt [2];
	logic [1:0] running;
	logic [1:0] done;
	logic [1:0] src [2];

	assign src[0] = ctrl[0][F_SRC_LO+:2];
	assign src[1] = casc ? 2'(DCT_S_CASC) : ctrl[1][F_SRC_LO+:2];

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			unique case (src[i])
				2'(DCT_S_EXT): tick[i] = clk_s2[i] && !clk_s3[i];
				2'(DCT_S_CASC): tick[i] = (i == 1) && clk_out[0];
				default: tick[i] = tb_tick;
			endcase
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_unit
		dct_unit u_unit (
			.i_clk(i_clk),
			.i_rstn(i_rstn),
			.i_en(ctrl[g][F_EN]),
			.i_mode(ctrl[g][F_MODE_LO+:3]),
			.i_gate_type(ctrl[g][F_GATE_LO+:3]),
			.i_pol(ctrl[g][F_POL]),
			.i_duty(ctrl[g][F_DUTY_LO+:8]),
			.i_div(div[g]),
			.i_tick(tick[g]),
			.i_gate(gt_s2[g]),
			.i_gate_rise(gt_s2[g] && !gt_s3[g]),
			.i_gate_fall(!gt_s2[g] && gt_s3[g]),
			.o_pulse(o_pulse[g]),
			.o_clk_out(clk_out[g]),
			.o_count(cnt[g]),
			.o_running(running[g]),
			.o_done(done[g])
		);
	end

	// ==============================================================
	// read port, data one cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (!i_rstn || !i_rd) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			unique case (i_addr)
				A_CTRL0: o_rdata <= ctrl[0];
				A_CTRL1: o_rdata <= ctrl[1];
				A_DIV0: o_rdata <= {16'h0000, div[0]};
				A_DIV1: o_rdata <= {16'h0000, div[1]};
				A_CNT0: o_rdata <= {16'h0000, cnt[0]};
				A_CNT1: o_rdata <= {16'h0000, cnt[1]};
				A_CASC: o_rdata <= {31'h0, casc};
				A_STAT: o_rdata <= {28'h0, done, running};
				default: o_rdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule : dct_top

// file: dct_pkg.sv
// package for the dual counter/timer pulse unit
// assumes a 100 MHz system clock and a plain register port
package dct_pkg;
	localparam int CLK_HZ = 100000000;
	localparam int TB_HZ = 12000000;
	// time base tick every CLK_HZ/TB_HZ cycles (rounded down)
	localparam int TB_DIV = CLK_HZ / TB_HZ;
	localparam logic [3:0] TB_DIV_M1 = 4'(TB_DIV - 1);
	localparam int MIN_PULSE_NS = 650;
	localparam logic [7:0] DUTY_FULL = 8'h64;
	localparam logic [7:0] DUTY_HALF = 8'h32;
	// register byte addresses (byte address = 4*index)
	localparam logic [7:0] A_CTRL0 = 8'h00;
	localparam logic [7:0] A_DIV0 = 8'h04;
	localparam logic [7:0] A_CNT0 = 8'h08;
	localparam logic [7:0] A_CTRL1 = 8'h10;
	localparam logic [7:0] A_DIV1 = 8'h14;
	localparam logic [7:0] A_CNT1 = 8'h18;
	localparam logic [7:0] A_CASC = 8'h20;
	localparam logic [7:0] A_STAT = 8'h24;
	// control word fields
	localparam int F_EN = 0;
	localparam int F_MODE_LO = 1;
	localparam int F_SRC_LO = 4;
	localparam int F_GATE_LO = 6;
	localparam int F_POL = 9;
	localparam int F_DUTY_LO = 16;
	localparam logic [31:0] CTRL_RST = 32'h0032_0000;
	localparam logic [15:0] DIV_RST = 16'hFFFF;
	typedef enum logic [2:0] {
		DCT_M_COUNT, DCT_M_FREQ, DCT_M_RATE, DCT_M_ONESHOT, DCT_M_REPEAT
	} dct_mode_t;
	typedef enum logic [1:0] {
		DCT_S_INT, DCT_S_EXT, DCT_S_CASC
	} dct_src_t;
	typedef enum logic [2:0] {
		DCT_G_NONE, DCT_G_LOW, DCT_G_HIGH, DCT_G_FALL, DCT_G_RISE
	} dct_gate_t;
endpackage : dct_pkg

// file: dct_unit.sv
// one 16-bit counter/timer channel
// assumes clock and gate already synchronised and a one-cycle tick
`timescale 1ns/10ps
module dct_unit
	import dct_pkg::*;
(
	input wire logic i_clk, // system clock
	input wire logic i_rstn, // sync reset, low
	input wire logic i_en, // software enable
	input wire logic [2:0] i_mode, // operating mode
	input wire logic [2:0] i_gate_type, // gate type
	input wire logic i_pol, // 1: low-to-high active high
	input wire logic [7:0] i_duty, // duty percent
	input wire logic [15:0] i_div, // reload minus one
	input wire logic i_tick, // one active clock edge
	input wire logic i_gate, // synced gate level
	input wire logic i_gate_rise, // gate rising edge
	input wire logic i_gate_fall, // gate falling edge
	output logic o_pulse, // pulse output
	output logic o_clk_out, // one-cycle tick per period end
	output logic [15:0] o_count, // event count (ticks while active)
	output logic o_running, // operation active
	output logic o_done // one-shot finished
);
	// ==============================================================
	// gate qualification
	logic gate_ok;
	logic trig;
	logic armed;
	logic firing;
	logic active;
	logic [15:0] phase;
	logic [23:0] duty_prod;
	logic [16:0] thresh;
	logic shot_mode;
	logic pulse_on;

	assign shot_mode = (i_mode == 3'(DCT_M_ONESHOT))
		|| (i_mode == 3'(DCT_M_REPEAT));
	always_comb begin
		unique case (i_gate_type)
			3'(DCT_G_LOW): gate_ok = !i_gate;
			3'(DCT_G_HIGH): gate_ok = i_gate;
			default: gate_ok = 1'b1;
		endcase
	end
	always_comb begin
		unique case (i_gate_type)
			3'(DCT_G_FALL): trig = i_gate_fall;
			3'(DCT_G_RISE): trig = i_gate_rise;
			default: trig = !armed && !o_done;
		endcase
	end

	// ==============================================================
	// one-shot arming: trigger waits for the next clock edge
	always_ff @(posedge i_clk) begin
		if (!i_rstn || !i_en || !shot_mode) begin
			armed <= 1'b0;
			o_done <= 1'b0;
		end else if (!armed && !o_done && trig) begin
			armed <= 1'b1;
		end else if (armed && firing && i_tick && phase == i_div) begin
			armed <= 1'b0;
			o_done <= (i_mode == 3'(DCT_M_ONESHOT));
		end
	end

	// pulse starts on the first tick after the trigger, lasts div+1 ticks
	always_ff @(posedge i_clk) begin
		if (!i_rstn || !i_en || !shot_mode) begin
			firing <= 1'b0;
		end else if (armed && i_tick) begin
			firing <= !(firing && phase == i_div);
		end
	end

	assign active = i_en && (shot_mode ? firing : gate_ok);
	assign o_running = active;

	// ==============================================================
	// period counter: reload i_div gives period i_div+1 ticks
	always_ff @(posedge i_clk) begin
		if (!i_rstn || !active) begin
			phase <= 16'h0000;
		end else if (i_tick) begin
			phase <= (phase == i_div) ? 16'h0000 : phase + 16'h0001;
		end
	end

	// event count wraps after 65,536 events
	always_ff @(posedge i_clk) begin
		if (!i_rstn || !i_en) begin
			o_count <= 16'h0000;
		end else if (active && i_tick) begin
			o_count <= o_count + 16'h0001;
		end
	end

	assign o_clk_out = active && i_tick && (phase == i_div);

	// ==============================================================
	// pulse shaping
	assign duty_prod = ({8'h00, i_div} + 24'h000001) * {16'h0000, i_duty};
	// 17 bits so that 100 % of a 65,536-tick period does not wrap to zero
	assign thresh = 17'(duty_prod / 24'(DUTY_FULL));
	assign pulse_on = shot_mode ? firing : ({1'b0, phase} < thresh);
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_pulse <= 1'b0;
		end else if (!active || i_mode == 3'(DCT_M_COUNT)
			|| i_mode == 3'(DCT_M_FREQ)) begin
			o_pulse <= !i_pol;
		end else begin
			o_pulse <= i_pol ? pulse_on : !pulse_on;
		end
	end
endmodule : dct_unit

// file: dct_properties.sv
// checker for the counter/timer unit, bound to its top
// assumes one clock domain and the plain register port
`timescale 1ns/10ps
module dct_properties
	import dct_pkg::*;
(
	input wire logic i_clk, // clock
	input wire logic i_rstn, // reset, low
	input wire logic [7:0] i_addr, // address
	input wire logic [31:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	input wire logic [31:0] o_rdata, // read data
	input wire logic [1:0] i_ext_clk, // external clocks
	input wire logic [1:0] i_gate, // gate pins
	input wire logic [1:0] o_pulse // pulse pins
);
	// ========
	// cycles since last write and last pulse change
	logic [7:0] wr_gap;
	logic [7:0] gap0;
	logic [7:0] gap1;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	always_ff @(posedge i_clk) wr_gap <= (!i_rstn || i_wr) ? 8'h00 :
		wr_gap + {7'h00, wr_gap != 8'hFF};
	always_ff @(posedge i_clk) gap0 <= (!i_rstn || $changed(o_pulse[0])) ?
		8'h00 : gap0 + {7'h00, gap0 != 8'hFF};
	always_ff @(posedge i_clk) gap1 <= (!i_rstn || $changed(o_pulse[1])) ?
		8'h00 : gap1 + {7'h00, gap1 != 8'hFF};
	// ========
	// assertions
	a_rdata_quiet: assert property (!i_rd |=> o_rdata == 32'h0)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (i_rd && i_addr == 8'hFC |=>
		o_rdata == 32'h0) else $error("unmapped read not zero");
	a_div_readback: assert property (i_wr && i_addr == A_DIV0 ##2
		i_rd && i_addr == A_DIV0 |=> o_rdata[15:0] == $past(i_wdata[15:0], 3))
		else $error("divider readback wrong");
	a_duty_readback: assert property (i_wr && i_addr == A_CTRL0 ##2
		i_rd && i_addr == A_CTRL0 |=> o_rdata[23:16] == $past(i_wdata[23:16], 3))
		else $error("duty readback wrong");
	a_pol_readback: assert property (i_wr && i_addr == A_CTRL1 ##2
		i_rd && i_addr == A_CTRL1 |=> o_rdata[9] == $past(i_wdata[9], 3))
		else $error("polarity readback wrong");
	a_casc_readback: assert property (i_wr && i_addr == A_CASC ##2
		i_rd && i_addr == A_CASC |=> o_rdata[0] == $past(i_wdata[0], 3))
		else $error("cascade readback wrong");
	a_tick_gap0: assert property ($changed(o_pulse[0]) && wr_gap > 8'h14
		|-> gap0 >= 8'h07) else $error("pulse 0 changed between ticks");
	a_tick_gap1: assert property ($changed(o_pulse[1]) && wr_gap > 8'h14
		|-> gap1 >= 8'h07) else $error("pulse 1 changed between ticks");
endmodule : dct_properties
bind dct_top dct_properties chk_u (.i_clk(i_clk), .i_rstn(i_rstn),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_ext_clk(i_ext_clk), .i_gate(i_gate),
	.o_pulse(o_pulse));

// file: dct_pins.sv
// far-side pin model: external clocks and gate levels
// assumes the bench sets run and gate level per channel
`timescale 1ns/10ps
module dct_pins (
	input wire logic [1:0] i_run, // clock run per channel
	input wire logic [1:0] i_lvl, // gate level per channel
	output logic [1:0] o_ext_clk, // external clocks
	output logic [1:0] o_gate // gate pins
);
	// ========
	// 714 kHz clock, parked low while stopped
	logic [1:0] clk_q = 2'h0;
	always #700 clk_q <= i_run & ~clk_q;
	assign o_ext_clk = clk_q;
	assign o_gate = i_lvl;
endmodule : dct_pins

// file: dct_top_tb.sv
// bench for the dual counter/timer unit
// assumes dct_pins on the pins and the bound checker
`timescale 1ns/10ps
module dct_top_tb
	import dct_pkg::*;
;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} dct_row_t;
	dct_row_t rows [8] = '{'{A_CTRL1, 32'h0046_0200, 32'h0046_0200},
		'{A_DIV1, 32'hABCD_0010, 32'h0000_0010}, '{A_CASC, 32'h1, 32'h1},
		'{A_CASC, 32'h0, 32'h0}, '{8'hFC, 32'hFFFF_FFFF, 32'h0},
		'{A_STAT, 32'hFFFF_FFFF, 32'h0}, '{A_CTRL0, 32'h0050_0000,
		32'h0050_0000}, '{A_DIV0, 32'h0000_000F, 32'h0000_000F}};
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic [1:0] ext_clk;
	logic [1:0] gate;
	logic [1:0] o_pulse;
	logic [1:0] run = 2'h0;
	logic [1:0] lvl = 2'h0;
	logic [31:0] v;
	int n;
	int n_errors = 0;
	int tests_run = 0;
	dct_top dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_ext_clk(ext_clk), .i_gate(gate), .o_pulse(o_pulse));
	dct_pins pins_u (.i_run(run), .i_lvl(lvl), .o_ext_clk(ext_clk),
		.o_gate(gate));
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	// ========
	// tasks
	task automatic give_verdict;
		if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	task automatic check(input logic [31:0] s, e, input string nm);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic step;
		@(posedge i_clk);
		#1;
	endtask : step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		{i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		{i_rd, i_addr} <= {1'b1, a};
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd
	task automatic span(input int c, input logic l, output int m);
		int k;
		k = 0;
		m = 0;
		while (o_pulse[c] !== l && k < 4000) begin
			step();
			k++;
		end
		while (o_pulse[c] === l && k < 4000) begin
			step();
			m++;
			k++;
		end
		if (k >= 4000) begin
			n_errors++;
			give_verdict();
		end
	endtask : span
	task automatic still(input int c, input int len);
		logic s;
		int k;
		s = o_pulse[c];
		k = 0;
		repeat (len) begin
			step();
			if (o_pulse[c] !== s) k++;
		end
		check(k, 0, "pulse changes");
	endtask : still
	task automatic burst(input logic [1:0] r);
		run <= r;
		repeat (700) step();
		run <= 2'b00;
		repeat (20) step();
	endtask : burst
	// ========
	// sequence
	initial begin
		repeat (4) @(posedge i_clk);
		i_rstn <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, v);
			check(v, rows[i].e, "readback");
		end
		{run, lvl} <= 4'hA;
		wr(A_DIV1, 32'h3);
		wr(A_CTRL1, 32'h0019_0095);
		span(1, 0, n);
		span(1, 1, n);
		check(n, 420, "ext high");
		span(1, 0, n);
		check(n, 140, "ext low");
		lvl <= 2'b00;
		still(1, 600);
		run <= 2'b00;
		wr(A_CTRL0, 32'h003C_0205);
		span(0, 1, n);
		span(0, 0, n);
		check(n, 7 * TB_DIV, "int low");
		span(0, 1, n);
		check(n, 9 * TB_DIV, "int high");
		wr(A_CTRL0, 32'h003C_0204);
		repeat (4) step();
		still(0, 300);
		check(o_pulse[0], 1'b0, "idle level");
		wr(A_CTRL0, 32'h0064_0307);
		lvl <= 2'b01;
		span(0, 1, n);
		check(n, 16 * TB_DIV, "one shot");
		lvl <= 2'b00;
		repeat (20) step();
		lvl <= 2'b01;
		still(0, 400);
		rd(A_STAT, v);
		check(v, 32'h4, "shot done");
		wr(A_CTRL0, 32'h0);
		wr(A_CTRL0, 32'h0064_02C9);
		repeat (2) begin
			lvl <= 2'b01;
			repeat (20) step();
			lvl <= 2'b00;
			span(0, 1, n);
			check(n, 16 * TB_DIV, "repeat shot");
		end
		wr(A_CTRL0, 32'h0032_0205);
		wr(A_CASC, 32'h1);
		wr(A_DIV1, 32'h1);
		wr(A_CTRL1, 32'h0032_0225);
		span(1, 1, n);
		span(1, 0, n);
		check(n, 16 * TB_DIV, "cascade");
		// ========
		// event counting: each burst gives five external rising edges
		wr(A_CASC, 32'h0);
		wr(A_CTRL1, 32'h0);
		wr(A_CTRL1, 32'h0000_0051);
		burst(2'b10);
		rd(A_CNT1, v);
		check(v, 32'h5, "event count");
		rd(A_STAT, v);
		check(v, 32'h3, "both running");
		lvl <= 2'b10;
		repeat (5) step();
		burst(2'b10);
		rd(A_CNT1, v);
		check(v, 32'h5, "gated count");
		rd(A_STAT, v);
		check(v, 32'h1, "gate halts");
		wr(A_CTRL1, 32'h0000_0093);
		burst(2'b10);
		rd(A_CNT1, v);
		check(v, 32'hA, "freq count");
		i_rstn <= 1'b0;
		repeat (4) step();
		i_rstn <= 1'b1;
		repeat (3) step();
		check(o_pulse, 2'b11, "reset pulse");
		rd(A_CTRL1, v);
		check(v, CTRL_RST, "ctrl reset");
		rd(A_DIV1, v);
		check(v, {16'h0, DIV_RST}, "div reset");
		rd(A_CNT1, v);
		check(v, 32'h0, "count reset");
		give_verdict();
	end
endmodule : dct_top_tb
